// ### hdl/bcpwm_top.sv
`timescale 1ns/10ps
// Contract
// RQ1: even link bit pairs channel with next odd; output on even pin only
// RQ2: after linking, even channel's compare value governs first
// RQ3: write to odd compare of linked pair takes over at next overflow
// RQ4: at each overflow, most recently written set becomes active
// RQ5: linked pair uses even control register; odd control has no effect
// RQ6: odd pin released to general-purpose use while linked
// RQ7: write into active set acts immediately, like unbuffered
// RQ8: software writes only the inactive set of a linked pair
// RQ9: toggle-on-overflow toggles pin at counter modulo value
// RQ10: period equals interval between overflows, modulo and prescaler set
// RQ11: pulse width runs from overflow to compare match
// RQ12: select lo 0 clears pin on compare; 1 sets it
// RQ13: modulo N gives N+1 ticks per period
// RQ14: compare value sets pulse width in ticks; 128 of 256 is half
// RQ15: unbuffered write acts at once; compare only on equal match
// RQ16: software shortens pulse by writing in compare handler
// RQ17: software lengthens pulse by writing in overflow handler
// RQ18: software avoids toggle-on-compare for PWM
// RQ19: mode 0:1 unbuffered, 1:0 buffered; link bit beats select lo
// RQ20: toggle-on-overflow off gives no toggle, 0% duty
// RQ21: full-duty plus toggle-on-overflow gives constant 100% output
// RQ22: overflow flag at modulo; channel flag on each compare
// RQ23: counter returns to zero after modulo; that wrap is the overflow
module bcpwm_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins: drive value and timer ownership per pin
  output logic [bcpwm_pkg::NUM_CH-1:0] chan_pin_out,
  output logic [bcpwm_pkg::NUM_CH-1:0] chan_pin_owned
);
  localparam int N = bcpwm_pkg::NUM_CH;
  localparam int W = bcpwm_pkg::CNT_W;

  bcpwm_pkg::bcpwm_bus_state_t state;
  bcpwm_pkg::bcpwm_bus_state_t next_state;
  logic [7:0] ch_ctrl [N];
  logic [7:0] next_ch_ctrl [N];
  logic [W-1:0] ch_cmp [N];
  logic [W-1:0] next_ch_cmp [N];
  logic [7:0] tctrl;
  logic [7:0] next_tctrl;
  logic [W-1:0] modulo;
  logic [W-1:0] next_modulo;
  logic [bcpwm_pkg::NUM_PAIRS-1:0] odd_active;
  logic [bcpwm_pkg::NUM_PAIRS-1:0] next_odd_active;
  logic [bcpwm_pkg::NUM_PAIRS-1:0] odd_pending;
  logic [bcpwm_pkg::NUM_PAIRS-1:0] next_odd_pending;
  logic tof_armed;
  logic next_tof_armed;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [N-1:0] next_pin_out;
  logic [N-1:0] next_pin_owned;

  bcpwm_pkg::bcpwm_time_t tb;
  logic [N-1:0] ch_pin;
  logic [N-1:0] ch_match;
  logic [N-1:0] ch_enable;
  logic [N-1:0] linked_odd;
  logic [W-1:0] eff_cmp [N];

  logic wr_acc;
  logic rd_acc;
  logic [2:0] sel_ch;
  logic sel_is_cmp;
  logic sel_ch_hit;

  bcpwm_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .stop(tctrl[bcpwm_pkg::F_STOP]),
    .clear(tctrl[bcpwm_pkg::F_RST]),
    .prescale_sel(tctrl[bcpwm_pkg::F_PS +: bcpwm_pkg::PS_W]),
    .modulo(modulo),
    .tb(tb)
  );

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      if (gi % 2 == 0) begin : g_even
        localparam int P = gi / 2;
        // link bit on even channel overrides its select lo bit
        assign linked_odd[gi] = 1'b0;
        assign ch_enable[gi] = ch_ctrl[gi][bcpwm_pkg::F_MS_HI] ||
          (ch_ctrl[gi][bcpwm_pkg::F_MS_LO] &&
           !ch_ctrl[gi][bcpwm_pkg::F_MS_HI]); // RQ19
        assign eff_cmp[gi] = (ch_ctrl[gi][bcpwm_pkg::F_MS_HI] &&
          odd_active[P]) ? ch_cmp[gi+1] : ch_cmp[gi]; // RQ1 RQ4 RQ7
      end else begin : g_odd
        assign linked_odd[gi] = ch_ctrl[gi-1][bcpwm_pkg::F_MS_HI];
        // odd control is ignored while its pair is linked
        assign ch_enable[gi] = !linked_odd[gi] &&
          ch_ctrl[gi][bcpwm_pkg::F_MS_LO]; // RQ5
        assign eff_cmp[gi] = ch_cmp[gi];
      end
      bcpwm_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .tb(tb),
        .enable(ch_enable[gi]),
        .ctrl(ch_ctrl[gi]),
        .cmp(eff_cmp[gi]),
        .pin(ch_pin[gi]),
        .match(ch_match[gi])
      );
    end
  endgenerate

  always_comb begin
    wr_acc = psel && penable && pwrite && (state == bcpwm_pkg::BCPWM_ACCESS);
    rd_acc = psel && penable && !pwrite &&
      (state == bcpwm_pkg::BCPWM_ACCESS);
    sel_ch = 3'(paddr[6:3]);
    sel_is_cmp = paddr[2];
    sel_ch_hit = (paddr < bcpwm_pkg::ADDR_CTRL) && (paddr[1:0] == 2'b00);
  end

  // apb handshake: no wait state, answer in access cycle after setup
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = '0;
    case (state)
      bcpwm_pkg::BCPWM_IDLE: begin
        if (psel && !penable) begin
          next_state = bcpwm_pkg::BCPWM_ACCESS;
          next_pready = 1'b1;
          next_pslverr = !(sel_ch_hit || paddr == bcpwm_pkg::ADDR_CTRL ||
            paddr == bcpwm_pkg::ADDR_MOD || paddr == bcpwm_pkg::ADDR_CNT);
          if (!pwrite) begin
            if (sel_ch_hit && sel_is_cmp) begin
              next_prdata = {16'h0000, ch_cmp[sel_ch]};
            end else if (sel_ch_hit) begin
              next_prdata = {24'h000000, ch_ctrl[sel_ch]};
            end else if (paddr == bcpwm_pkg::ADDR_CTRL) begin
              next_prdata = {24'h000000, tctrl};
            end else if (paddr == bcpwm_pkg::ADDR_MOD) begin
              next_prdata = {16'h0000, modulo};
            end else if (paddr == bcpwm_pkg::ADDR_CNT) begin
              next_prdata = {16'h0000, tb.cnt};
            end
          end
        end
      end
      bcpwm_pkg::BCPWM_ACCESS: begin
        next_state = bcpwm_pkg::BCPWM_IDLE;
      end
      default: next_state = bcpwm_pkg::BCPWM_IDLE;
    endcase
  end

  // register file, flags and buffer selection
  always_comb begin
    next_tctrl = tctrl;
    next_modulo = modulo;
    next_odd_active = odd_active;
    next_odd_pending = odd_pending;
    next_tof_armed = tof_armed;
    next_tctrl[bcpwm_pkg::F_RST] = 1'b0;
    for (int i = 0; i < N; i++) begin
      next_ch_ctrl[i] = ch_ctrl[i];
      next_ch_cmp[i] = ch_cmp[i];
    end
    if (rd_acc && paddr == bcpwm_pkg::ADDR_CTRL &&
        tctrl[bcpwm_pkg::F_TOF]) begin
      next_tof_armed = 1'b1;
    end
    if (wr_acc && paddr == bcpwm_pkg::ADDR_MOD) begin
      next_modulo = pwdata[W-1:0];
    end
    if (wr_acc && paddr == bcpwm_pkg::ADDR_CTRL) begin
      next_tctrl[6:0] = pwdata[6:0];
      // flag cleared by read-then-write-zero; set below still wins
      if (!pwdata[bcpwm_pkg::F_TOF] && tof_armed) begin
        next_tctrl[bcpwm_pkg::F_TOF] = 1'b0;
      end
      next_tof_armed = 1'b0;
    end
    for (int i = 0; i < N; i++) begin
      if (wr_acc && sel_ch_hit && sel_ch == 3'(i)) begin
        if (sel_is_cmp) begin
          next_ch_cmp[i] = pwdata[W-1:0]; // RQ15
        end else begin
          next_ch_ctrl[i][6:0] = pwdata[6:0];
          if (!pwdata[bcpwm_pkg::F_FLAG]) begin
            next_ch_ctrl[i][bcpwm_pkg::F_FLAG] = 1'b0;
          end
        end
      end
      if (ch_match[i]) begin
        next_ch_ctrl[i][bcpwm_pkg::F_FLAG] = 1'b1; // RQ22
      end
    end
    for (int p = 0; p < bcpwm_pkg::NUM_PAIRS; p++) begin
      // last written set wins at overflow; write to active set is direct
      if (wr_acc && sel_ch_hit && sel_is_cmp && sel_ch == 3'(2*p+1)) begin
        next_odd_pending[p] = 1'b1; // RQ3
      end else if (wr_acc && sel_ch_hit && sel_is_cmp &&
                   sel_ch == 3'(2*p)) begin
        next_odd_pending[p] = 1'b0; // RQ4
      end
      if (tb.ovf) begin
        next_odd_active[p] = next_odd_pending[p]; // RQ3 RQ4
      end
      if (!ch_ctrl[2*p][bcpwm_pkg::F_MS_HI]) begin
        next_odd_active[p] = 1'b0; // RQ2
        next_odd_pending[p] = 1'b0;
      end
    end
    if (tb.ovf) begin
      next_tctrl[bcpwm_pkg::F_TOF] = 1'b1; // RQ22
    end
    for (int i = 0; i < N; i++) begin
      next_pin_out[i] = ch_pin[i];
      next_pin_owned[i] = ch_enable[i] && !linked_odd[i]; // RQ6 RQ1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bcpwm_pkg::BCPWM_IDLE;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tctrl <= bcpwm_pkg::TCTRL_RESET;
      modulo <= bcpwm_pkg::MOD_RESET;
      odd_active <= '0;
      odd_pending <= '0;
      tof_armed <= 1'b0;
      chan_pin_out <= '0;
      chan_pin_owned <= '0;
      for (int i = 0; i < N; i++) begin
        ch_ctrl[i] <= bcpwm_pkg::CH_CTRL_RESET;
        ch_cmp[i] <= bcpwm_pkg::CMP_RESET;
      end
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      tctrl <= next_tctrl;
      modulo <= next_modulo;
      odd_active <= next_odd_active;
      odd_pending <= next_odd_pending;
      tof_armed <= next_tof_armed;
      chan_pin_out <= next_pin_out;
      chan_pin_owned <= next_pin_owned;
      for (int i = 0; i < N; i++) begin
        ch_ctrl[i] <= next_ch_ctrl[i];
        ch_cmp[i] <= next_ch_cmp[i];
      end
    end
  end
endmodule : bcpwm_top

// ### hdl/bcpwm_pkg.sv
package bcpwm_pkg;
  localparam int NUM_CH = 6;
  localparam int NUM_PAIRS = 3;
  localparam int CNT_W = 16;
  localparam int PS_W = 3;
  // word byte addresses: status/control i at 0x00+8i, compare i at 0x04+8i
  localparam logic [7:0] ADDR_CTRL = 8'h30;
  localparam logic [7:0] ADDR_MOD = 8'h34;
  localparam logic [7:0] ADDR_CNT = 8'h38;
  localparam logic [7:0] ADDR_CH_BASE = 8'h00;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_CMP_OFS = 8'h04;
  // channel control field positions
  localparam int F_FULL = 0;
  localparam int F_TOV = 1;
  localparam int F_ELS_LO = 2;
  localparam int F_ELS_HI = 3;
  localparam int F_MS_LO = 4;
  localparam int F_MS_HI = 5;
  localparam int F_IE = 6;
  localparam int F_FLAG = 7;
  // timer control field positions
  localparam int F_PS = 0;
  localparam int F_STOP = 4;
  localparam int F_RST = 5;
  localparam int F_TOIE = 6;
  localparam int F_TOF = 7;
  localparam logic [7:0] CH_CTRL_RESET = 8'h00;
  localparam logic [7:0] TCTRL_RESET = 8'h10;
  localparam logic [CNT_W-1:0] MOD_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
    logic ovf;
  } bcpwm_time_t;

  typedef enum logic [1:0] {
    BCPWM_IDLE,
    BCPWM_ACCESS
  } bcpwm_bus_state_t;
endpackage : bcpwm_pkg

// ### hdl/bcpwm_counter.sv
`timescale 1ns/10ps
module bcpwm_counter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic stop,
  input wire logic clear,
  input wire logic [bcpwm_pkg::PS_W-1:0] prescale_sel,
  input wire logic [bcpwm_pkg::CNT_W-1:0] modulo,
  // time base out
  output bcpwm_pkg::bcpwm_time_t tb
);
  logic [6:0] div;
  logic [6:0] next_div;
  logic [bcpwm_pkg::CNT_W-1:0] cnt;
  logic [bcpwm_pkg::CNT_W-1:0] next_cnt;
  logic tick;
  logic wrap;

  always_comb begin
    next_div = div + 7'h01;
    // prescaler select n ticks once per 2^n bus clocks
    tick = !stop && ((div & ((7'h01 << prescale_sel) - 7'h01)) == 7'h00);
    wrap = tick && (cnt == modulo);
    next_cnt = cnt;
    if (clear) begin
      next_cnt = '0;
      next_div = '0;
    end else if (stop) begin
      next_div = div;
    end else if (tick) begin
      next_cnt = wrap ? '0 : cnt + 16'h0001; // RQ23 RQ13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      cnt <= '0;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
    end
  end

  always_comb begin
    tb.cnt = cnt;
    tb.tick = tick && !clear;
    tb.ovf = wrap && !clear; // RQ10
  end
endmodule : bcpwm_counter

// ### hdl/bcpwm_channel.sv
`timescale 1ns/10ps
module bcpwm_channel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // time base
  input bcpwm_pkg::bcpwm_time_t tb,
  // configuration
  input wire logic enable,
  input wire logic [7:0] ctrl,
  input wire logic [bcpwm_pkg::CNT_W-1:0] cmp,
  // results
  output logic pin,
  output logic match
);
  logic next_pin;
  logic tov;
  logic full;
  logic els_lo;
  logic els_hi;

  always_comb begin
    tov = ctrl[bcpwm_pkg::F_TOV];
    full = ctrl[bcpwm_pkg::F_FULL];
    els_lo = ctrl[bcpwm_pkg::F_ELS_LO];
    els_hi = ctrl[bcpwm_pkg::F_ELS_HI];
    // match on the count being entered, so high time is cmp ticks, not cmp+1
    match = enable && tb.tick &&
      ((tb.ovf ? 16'h0000 : tb.cnt + 16'h0001) == cmp); // RQ15 RQ22 RQ14
    next_pin = pin;
    if (enable && full && tov) begin
      next_pin = !els_lo; // RQ21
    end else if (enable && match) begin
      case ({els_hi, els_lo})
        2'b01: next_pin = !pin;
        2'b10: next_pin = 1'b0; // RQ12 RQ11
        2'b11: next_pin = 1'b1; // RQ12
        default: next_pin = pin;
      endcase
    end else if (enable && tb.ovf && tov) begin
      next_pin = !pin; // RQ9 RQ20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
    end else begin
      pin <= next_pin;
    end
  end
endmodule : bcpwm_channel

// ### bench/bcpwm_sva.sv
`timescale 1ns/10ps
module bcpwm_sva (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [bcpwm_pkg::NUM_CH-1:0] chan_pin_out,
  input wire logic [bcpwm_pkg::NUM_CH-1:0] chan_pin_owned
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic wdone = psel && penable && pready && pwrite;
  apb_ready_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property ($rose(pready) |-> $past(setup))
    else $error("ready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (setup && paddr == 8'h3c |=> pslverr)
    else $error("unmapped address accepted");
  mapped_ok_a: assert property (setup && paddr <= 8'h38
    && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped address refused");
  link_release_a: assert property (
    wdone && paddr == 8'h00 && pwdata[5]
    |-> ##[1:4] (!chan_pin_owned[1] && chan_pin_owned[0]))
    else $error("linked odd pin not released");
endmodule : bcpwm_sva

bind bcpwm_top bcpwm_sva u_bcpwm_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_pin_out(chan_pin_out), .chan_pin_owned(chan_pin_owned));

// ### bench/bcpwm_load.sv
`timescale 1ns/10ps
module bcpwm_load (
  // pin from the timer
  input wire logic pclk,
  input wire logic drive,
  input wire logic owned,
  // wire level and measured timing
  output logic level,
  output logic [15:0] period,
  output logic [15:0] high
);
  logic [15:0] run = 16'h0;
  logic [15:0] hrun = 16'h0;
  logic last = 1'b0;
  // pull-down: a released pin reads low, not the last driven value
  assign level = owned ? drive : 1'b0;
  // timing taken between rising edges, so pin latency cancels out
  always @(posedge pclk) begin
    last <= level;
    if (level && !last) begin
      period <= run + 16'h1;
      high <= hrun;
      run <= 16'h0;
      hrun <= 16'h1;
    end else begin
      run <= run + 16'h1;
      hrun <= hrun + {15'h0, level};
    end
  end
endmodule : bcpwm_load

// ### bench/test_buffered_compare_pwm_channels.sv
`timescale 1ns/10ps
module test_buffered_compare_pwm_channels;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic err;
  } bcpwm_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [bcpwm_pkg::NUM_CH-1:0] pin_out;
  logic [bcpwm_pkg::NUM_CH-1:0] pin_owned;
  logic [5:0] level;
  logic [15:0] period [6];
  logic [15:0] high [6];
  logic [31:0] q;
  logic e;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  bcpwm_row_t rows [17];

  bcpwm_top u_bcpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_pin_out(pin_out), .chan_pin_owned(pin_owned));
  for (genvar i = 0; i < 6; i++) begin : g_load
    bcpwm_load u_bcpwm_load (.pclk(pclk), .drive(pin_out[i]),
      .owned(pin_owned[i]), .level(level[i]), .period(period[i]),
      .high(high[i]));
  end

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pw(input int ch, input logic [15:0] p,
                    input logic [15:0] h);
    repeat (24) @(posedge pclk);
    chk(32'(period[ch]), 32'(p));
    chk(32'(high[ch]), 32'(h));
  endtask : pw

  task automatic steady(input int ch, input logic v);
    repeat (16) begin
      @(posedge pclk);
      chk(32'(level[ch]), 32'(v));
    end
  endtask : steady

  initial begin
    rows = '{'{0, 8'h30, 32'h10, 0}, '{0, 8'h34, 32'hffff, 0},
      '{0, 8'h00, 32'h0, 0}, '{0, 8'h2c, 32'h0, 0},
      '{0, 8'h38, 32'h0, 0}, '{0, 8'h3c, 32'h0, 1},
      '{1, 8'h3c, 32'h5, 1}, '{1, 8'h34, 32'h7, 0},
      '{0, 8'h34, 32'h7, 0}, '{1, 8'h14, 32'h3, 0},
      '{1, 8'h10, 32'h1a, 0}, '{0, 8'h10, 32'h1a, 0},
      '{1, 8'h04, 32'h2, 0}, '{1, 8'h00, 32'h2a, 0},
      '{1, 8'h20, 32'h1b, 0}, '{0, 8'h20, 32'h1b, 0},
      '{1, 8'h30, 32'h0, 0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].d);
      chk(32'(e), 32'(rows[i].err));
    end
    $display("register table done");
    pw(2, 16'h8, 16'h3);
    pw(0, 16'h8, 16'h2);
    chk(32'(pin_owned[1:0]), 32'h1);
    steady(4, 1'b1);
    $display("pwm basics done");
    apb(1'b1, 8'h0c, 32'h5);
    pw(0, 16'h8, 16'h5);
    apb(1'b1, 8'h08, 32'h1a);
    pw(0, 16'h8, 16'h5);
    chk(32'(pin_owned[1]), 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    pw(0, 16'h8, 16'h1);
    apb(1'b1, 8'h04, 32'h4);
    pw(0, 16'h8, 16'h4);
    $display("buffered pair done");
    apb(1'b1, 8'h10, 32'h1e);
    pw(2, 16'h8, 16'h5);
    apb(1'b1, 8'h20, 32'h18);
    repeat (20) @(posedge pclk);
    steady(4, 1'b0);
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(q[7]), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(q[7]), 32'h1);
    $display("polarity and flags done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(pin_owned), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h10);
    $display("mid-run reset done");
    end_sim();
  end
endmodule : test_buffered_compare_pwm_channels
